// [core/cgcs_pkg.sv]
// Package: register map, field positions and shared types of the CAN general block
package cgcs_pkg;

  // Register offsets on the plain register port
  localparam logic [2:0] ADDR_GCON  = 3'h0;
  localparam logic [2:0] ADDR_GSTA  = 3'h1;
  localparam logic [2:0] ADDR_GIT   = 3'h2;
  localparam logic [2:0] ADDR_GIE   = 3'h3;
  localparam logic [2:0] ADDR_BUSYL = 3'h4;
  localparam logic [2:0] ADDR_BUSYH = 3'h5;

  // General control bit positions
  localparam int GCON_ABORT   = 7;
  localparam int GCON_OVLREQ  = 6;
  localparam int GCON_TTMODE  = 5;
  localparam int GCON_SYNC    = 4;
  localparam int GCON_LISTEN  = 3;
  localparam int GCON_TEST    = 2;
  localparam int GCON_ENA     = 1;
  localparam int GCON_SOFTRST = 0;

  // General status bit positions
  localparam int GSTA_OVL     = 6;
  localparam int GSTA_TXB     = 4;
  localparam int GSTA_RXB     = 3;
  localparam int GSTA_ENF     = 2;
  localparam int GSTA_BUSOFF  = 1;
  localparam int GSTA_PASSIVE = 0;

  // Interrupt flag / enable bit positions
  localparam int GIT_SUM   = 7;
  localparam int GIT_BUSOFF = 6;
  localparam int GIT_OVRT  = 5;
  localparam int GIT_BX    = 4;
  localparam int GIE_ALL   = 7;
  localparam int GIE_BUSOFF = 6;
  localparam int GIE_RX    = 5;
  localparam int GIE_TX    = 4;
  localparam int GIE_ERR   = 3;
  localparam int GIE_BX    = 2;
  localparam int GIE_ERG   = 1;
  localparam int GIE_OVRT  = 0;

  // Reset values
  localparam logic [7:0] GCON_RST = 8'h00;
  localparam logic [7:0] GIT_RST  = 8'h00;
  localparam logic [7:0] GIE_RST  = 8'h00;

  // Counts
  localparam int          NUM_OBJ        = 15;
  localparam logic [3:0]  RECESSIVE_BITS = 4'hB;

  // Events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic                sof;          // Start of frame seen
    logic                eof_last;     // Last bit of end of frame
    logic                bit_tick;     // One bus bit sampled
    logic                bus_level;    // Sampled level, 1 recessive
    logic                timer_wrap;   // Timer rolled over to zero
    logic                frame_buf_done;
    logic                stuff_err;
    logic                crc_err;
    logic                form_err;
    logic                ack_err;
    logic [NUM_OBJ-1:0]  obj_enable;   // Object configured enabled
    logic [NUM_OBJ-1:0]  obj_disable;  // Object configured disabled
    logic [NUM_OBJ-1:0]  obj_rx_ok;
    logic [NUM_OBJ-1:0]  obj_tx_ok;
    logic                buf_cfg_rewritten; // All buffer objects rewritten
  } cgcs_evt_t;

  // Levels from the protocol engine
  typedef struct packed {
    logic overload_tx;
    logic tx_active;
    logic rx_active;
    logic bus_off;
    logic error_passive;
    logic obj_rx_irq;   // Any object receive-OK pending
    logic obj_tx_irq;
    logic obj_err_irq;
  } cgcs_lvl_t;

  // Controls handed to the protocol engine
  typedef struct packed {
    logic time_triggered_mode;
    logic trigger_sync_select;
    logic listen_mode;
    logic test_mode;
    logic overload_req;
    logic abort_request;
    logic enabled_state;
    logic freeze;         // Channel frozen, recessive drive, rx off
    logic trig_capture;   // Capture time-trigger timer now
    logic ctrl_reset;     // Soft reset of the controller only
  } cgcs_ctl_t;

endpackage

// [core/cgcs_busy_vec.sv]
// Per-object busy vector of the CAN general block
`timescale 1ns/1ps
module cgcs_busy_vec (
  input  wire logic                        sys_clk,
  input  wire logic                        rst,
  input  wire logic                        ctrl_reset,
  input  wire logic [cgcs_pkg::NUM_OBJ-1:0] set_vec,
  input  wire logic [cgcs_pkg::NUM_OBJ-1:0] clr_vec,
  input  wire logic                        clr_all,
  output logic      [cgcs_pkg::NUM_OBJ-1:0] busy_r
);

  typedef struct packed {
    logic [cgcs_pkg::NUM_OBJ-1:0] busy;
  } cgcs_bv_st_t;

  cgcs_bv_st_t st_r;
  cgcs_bv_st_t st_nxt;

  // Clears win over a set in the same cycle: a finished object is free
  always_comb begin
    st_nxt = st_r;
    for (int i = 0; i < cgcs_pkg::NUM_OBJ; i++) begin
      if (clr_all || clr_vec[i]) begin
        st_nxt.busy[i] = 1'b0;
      end else if (set_vec[i]) begin
        st_nxt.busy[i] = 1'b1;
      end
    end
    if (ctrl_reset) begin
      st_nxt.busy = '0;
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_r = st_r.busy;

endmodule // cgcs_busy_vec

// [core/cgcs_top.sv]
// General control, status and interrupt logic of the CAN controller
//
// How it works
// - Control bit 5 selects time-triggered mode; clear is normal operation.
// - Sync select picks capture at start or end of frame, time-triggered only.
// - Control bit 3 selects listening mode.
// - Enable command acts later; status enabled flag shows mode in force.
// - Standby ends transmission, then freezes: recessive drive, receiver off.
// - Enable mode entered only after 11 recessive bits read.
// - Soft reset bit resets controller only, ORed with hardware, self-clears.
// - Overload flag high while own overload frame sent, no interrupt.
// - Transmitter busy high while any frame field or spacing sent.
// - Receiver busy high while frame received or monitored.
// - Status bit 1 bus-off, bit 0 error-passive, latter no interrupt.
// - Bus-off flag sets on error-passive to bus-off; write 1 clears.
// - Summary bit 7 is OR of all sources except timer overrun.
// - Timer overrun flag sets on wrap; cleared by write 1 or handler.
// - Frame-buffer flag sets on completion; clear needs objects rewritten.
// - Bits 3..0 record stuff, CRC, form, ack errors; write 1 clears.
// - Enable 7 gates all but overrun; overrun gated by enable 0.
// - Enables 6..1 gate bus-off, rx, tx, object error, buffer, general.
// - Fifteen busy bits set when their object is enabled.
// - Busy bit clears on rx/tx OK, disable, abort or standby.
// - Abort clears the whole busy vector; ongoing frame finishes.
// - Writing 0 to an interrupt flag leaves it unchanged.
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module cgcs_top (
  input  wire logic                sys_clk,
  input  wire logic                rst,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [7:0]          reg_rdata,
  input  wire cgcs_pkg::cgcs_evt_t eng_evt,
  input  wire cgcs_pkg::cgcs_lvl_t eng_lvl,
  input  wire logic                ovrt_handler_ack,
  output cgcs_pkg::cgcs_ctl_t      eng_ctl,
  output logic                     can_irq,
  output logic                     ovrt_irq
);

  typedef enum logic [1:0] {
    CGCS_STANDBY,
    CGCS_WAIT_IDLE,
    CGCS_ENABLED
  } cgcs_mode_t;

  typedef struct packed {
    logic [7:0]          gcon;
    logic [7:0]          git;     // Bit 7 unused here; summary computed
    logic [7:0]          gie;
    cgcs_mode_t          mode;
    logic [3:0]          rec_cnt;
    logic                prev_passive;
    logic                prev_busoff;
    logic                softrst_hold;
    logic [7:0]          rdata;
    cgcs_pkg::cgcs_ctl_t ctl;
    logic                can_irq;
    logic                ovrt_irq;
  } cgcs_st_t;

  cgcs_st_t st_r;
  cgcs_st_t st_nxt;

  logic [cgcs_pkg::NUM_OBJ-1:0] busy_vec;
  logic [cgcs_pkg::NUM_OBJ-1:0] busy_clr;
  logic                         busy_clr_all;
  logic                         summary;
  logic                         ctrl_reset;
  logic [7:0]                   status;
  logic [7:0]                   git_view;
  logic                         wr_git;
  logic [7:0]                   git_clr;

  // Soft reset from last cycle's request, ORed in for the whole block
  assign ctrl_reset = st_r.softrst_hold;

  // Busy clears: object finished, disabled, abort held, or standby in force
  assign busy_clr     = eng_evt.obj_rx_ok | eng_evt.obj_tx_ok
                        | eng_evt.obj_disable;
  assign busy_clr_all = st_r.gcon[cgcs_pkg::GCON_ABORT]
                        || (st_r.mode == CGCS_STANDBY);

  cgcs_busy_vec u_busy (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .ctrl_reset (ctrl_reset),
    .set_vec    (eng_evt.obj_enable),
    .clr_vec    (busy_clr),
    .clr_all    (busy_clr_all),
    .busy_r     (busy_vec)
  );

  // Summary: every general source under its enable, overrun excluded
  assign summary =
      (st_r.git[cgcs_pkg::GIT_BUSOFF] && st_r.gie[cgcs_pkg::GIE_BUSOFF])
    || (eng_lvl.obj_rx_irq && st_r.gie[cgcs_pkg::GIE_RX])
    || (eng_lvl.obj_tx_irq && st_r.gie[cgcs_pkg::GIE_TX])
    || (eng_lvl.obj_err_irq && st_r.gie[cgcs_pkg::GIE_ERR])
    || (st_r.git[cgcs_pkg::GIT_BX] && st_r.gie[cgcs_pkg::GIE_BX])
    || ((|st_r.git[3:0]) && st_r.gie[cgcs_pkg::GIE_ERG]);

  // Status image; reserved bits read zero
  always_comb begin
    status = 8'h00;
    status[cgcs_pkg::GSTA_OVL]  = eng_lvl.overload_tx;
    status[cgcs_pkg::GSTA_TXB]  = eng_lvl.tx_active;
    status[cgcs_pkg::GSTA_RXB]  = eng_lvl.rx_active;
    status[cgcs_pkg::GSTA_ENF]  = (st_r.mode == CGCS_ENABLED);
    status[cgcs_pkg::GSTA_BUSOFF]  = eng_lvl.bus_off;
    status[cgcs_pkg::GSTA_PASSIVE] = eng_lvl.error_passive;
  end

  // Flag view with the summary folded into bit 7
  always_comb begin
    git_view = st_r.git;
    git_view[cgcs_pkg::GIT_SUM] = summary;
  end

  // Write-one-to-clear mask; zeros leave flags alone
  assign wr_git = reg_wr && (reg_addr == cgcs_pkg::ADDR_GIT);
  always_comb begin
    git_clr = wr_git ? reg_wdata : 8'h00;
    git_clr[cgcs_pkg::GIT_SUM] = 1'b0;
    // Buffer flag only clears once its objects were reconfigured
    if (!eng_evt.buf_cfg_rewritten) begin
      git_clr[cgcs_pkg::GIT_BX] = 1'b0;
    end
    if (ovrt_handler_ack) begin
      git_clr[cgcs_pkg::GIT_OVRT] = 1'b1;
    end
  end

  // Next-state logic of the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.softrst_hold = 1'b0;

    // Register writes
    if (reg_wr && reg_addr == cgcs_pkg::ADDR_GCON) begin
      st_nxt.gcon = reg_wdata;
      // Soft reset is a pulse, never stored
      st_nxt.gcon[cgcs_pkg::GCON_SOFTRST] = 1'b0;
      st_nxt.softrst_hold = reg_wdata[cgcs_pkg::GCON_SOFTRST];
    end
    if (reg_wr && reg_addr == cgcs_pkg::ADDR_GIE) begin
      st_nxt.gie = reg_wdata;
    end

    // Flags: clear first, then sets so an event is never lost
    st_nxt.git = st_r.git & ~git_clr;
    st_nxt.git[cgcs_pkg::GIT_SUM] = 1'b0;
    if (eng_lvl.bus_off && !st_r.prev_busoff && st_r.prev_passive) begin
      st_nxt.git[cgcs_pkg::GIT_BUSOFF] = 1'b1;
    end
    if (eng_evt.timer_wrap) begin
      st_nxt.git[cgcs_pkg::GIT_OVRT] = 1'b1;
    end
    if (eng_evt.frame_buf_done) begin
      st_nxt.git[cgcs_pkg::GIT_BX] = 1'b1;
    end
    if (eng_evt.stuff_err) begin
      st_nxt.git[3] = 1'b1;
    end
    if (eng_evt.crc_err) begin
      st_nxt.git[2] = 1'b1;
    end
    if (eng_evt.form_err) begin
      st_nxt.git[1] = 1'b1;
    end
    if (eng_evt.ack_err) begin
      st_nxt.git[0] = 1'b1;
    end
    st_nxt.prev_passive = eng_lvl.error_passive;
    st_nxt.prev_busoff  = eng_lvl.bus_off;

    // Enable/standby sequencing
    unique case (st_r.mode)
      CGCS_STANDBY: begin
        st_nxt.rec_cnt = 4'h0;
        if (st_r.gcon[cgcs_pkg::GCON_ENA]) begin
          st_nxt.mode = CGCS_WAIT_IDLE;
        end
      end
      CGCS_WAIT_IDLE: begin
        if (!st_r.gcon[cgcs_pkg::GCON_ENA]) begin
          st_nxt.mode = CGCS_STANDBY;
        end else if (eng_evt.bit_tick) begin
          if (!eng_evt.bus_level) begin
            st_nxt.rec_cnt = 4'h0; // Dominant bit restarts the count
          end else if (st_r.rec_cnt == cgcs_pkg::RECESSIVE_BITS - 4'h1) begin
            st_nxt.mode = CGCS_ENABLED;
          end else begin
            st_nxt.rec_cnt = st_r.rec_cnt + 4'h1;
          end
        end
      end
      CGCS_ENABLED: begin
        // Ongoing transmission runs to its end before freezing
        if (!st_r.gcon[cgcs_pkg::GCON_ENA] && !eng_lvl.tx_active) begin
          st_nxt.mode = CGCS_STANDBY;
        end
      end
    endcase

    // Controls to the protocol engine
    st_nxt.ctl.time_triggered_mode = st_nxt.gcon[cgcs_pkg::GCON_TTMODE];
    st_nxt.ctl.trigger_sync_select = st_nxt.gcon[cgcs_pkg::GCON_SYNC];
    st_nxt.ctl.listen_mode   = st_nxt.gcon[cgcs_pkg::GCON_LISTEN];
    st_nxt.ctl.test_mode     = st_nxt.gcon[cgcs_pkg::GCON_TEST];
    st_nxt.ctl.overload_req  = st_nxt.gcon[cgcs_pkg::GCON_OVLREQ];
    st_nxt.ctl.abort_request = st_nxt.gcon[cgcs_pkg::GCON_ABORT];
    st_nxt.ctl.enabled_state = (st_nxt.mode == CGCS_ENABLED);
    st_nxt.ctl.freeze        = (st_nxt.mode != CGCS_ENABLED);
    // Capture point only matters in time-triggered mode
    st_nxt.ctl.trig_capture = st_r.gcon[cgcs_pkg::GCON_TTMODE]
      && (st_r.gcon[cgcs_pkg::GCON_SYNC] ? eng_evt.eof_last
                                         : eng_evt.sof);
    st_nxt.ctl.ctrl_reset = st_nxt.softrst_hold;

    // Interrupt requests
    st_nxt.can_irq  = summary && st_r.gie[cgcs_pkg::GIE_ALL];
    st_nxt.ovrt_irq = st_r.git[cgcs_pkg::GIT_OVRT]
                      && st_r.gie[cgcs_pkg::GIE_OVRT];

    // Read data, valid the cycle after the strobe; unmapped reads zero
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        cgcs_pkg::ADDR_GCON:  st_nxt.rdata = st_r.gcon;
        cgcs_pkg::ADDR_GSTA:  st_nxt.rdata = status;
        cgcs_pkg::ADDR_GIT:   st_nxt.rdata = git_view;
        cgcs_pkg::ADDR_GIE:   st_nxt.rdata = st_r.gie;
        cgcs_pkg::ADDR_BUSYL: st_nxt.rdata = busy_vec[7:0];
        cgcs_pkg::ADDR_BUSYH: st_nxt.rdata = {1'b0, busy_vec[14:8]};
        default:              st_nxt.rdata = 8'h00;
      endcase
    end

    // Soft reset returns controller state to its reset values
    if (ctrl_reset) begin
      st_nxt.gcon    = cgcs_pkg::GCON_RST;
      st_nxt.git     = cgcs_pkg::GIT_RST;
      st_nxt.gie     = cgcs_pkg::GIE_RST;
      st_nxt.mode    = CGCS_STANDBY;
      st_nxt.rec_cnt = 4'h0;
      st_nxt.can_irq = 1'b0;
      st_nxt.ovrt_irq = 1'b0;
      st_nxt.ctl     = '0;
      st_nxt.ctl.freeze = 1'b1;
    end
  end

  // State register, asynchronous hardware reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r            <= '0;
      st_r.mode       <= CGCS_STANDBY;
      st_r.ctl.freeze <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign eng_ctl   = st_r.ctl;
  assign can_irq   = st_r.can_irq;
  assign ovrt_irq  = st_r.ovrt_irq;

endmodule // cgcs_top

// [bench/cgcs_chk.sv]
// Checker of the CAN general control and status block, bound to its top
`timescale 1ns/1ps
module cgcs_chk (
  input wire logic                sys_clk,
  input wire logic                rst,
  input wire logic [2:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire cgcs_pkg::cgcs_evt_t eng_evt,
  input wire cgcs_pkg::cgcs_lvl_t eng_lvl,
  input wire logic                ovrt_handler_ack,
  input wire cgcs_pkg::cgcs_ctl_t eng_ctl,
  input wire logic                can_irq,
  input wire logic                ovrt_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic                gcon_wr;
  logic [3:0]          rec_r;
  logic                abort_r;
  logic                cap_r;
  logic [7:0]          gie_r;
  logic [7:0]          gie_p_r;
  logic [7:0]          wd_r;
  cgcs_pkg::cgcs_lvl_t lvl_r;
  assign gcon_wr = reg_wr && reg_addr == cgcs_pkg::ADDR_GCON;
  // Shadows; a control write restarts the recessive run count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rec_r <= 4'h0;
      abort_r <= 1'b0;
      cap_r <= 1'b0;
      gie_r <= 8'h00;
      gie_p_r <= 8'h00;
      wd_r <= 8'h00;
      lvl_r <= '0;
    end else begin
      if (gcon_wr) begin
        rec_r <= 4'h0;
        abort_r <= reg_wdata[7] & ~reg_wdata[0];
      end else if (eng_evt.bit_tick && !eng_evt.bus_level) begin
        rec_r <= 4'h0;
      end else if (eng_evt.bit_tick && rec_r != 4'hF) begin
        rec_r <= rec_r + 4'h1;
      end
      if (reg_wr && reg_addr == cgcs_pkg::ADDR_GIE) begin
        gie_r <= reg_wdata;
      end
      gie_p_r <= gie_r;
      wd_r <= reg_wdata;
      lvl_r <= eng_lvl;
      cap_r <= eng_ctl.time_triggered_mode && (eng_ctl.trigger_sync_select ?
               eng_evt.eof_last : eng_evt.sof);
    end
  end
  a_mode_bits: assert property (
    gcon_wr && !reg_wdata[0] |=> {eng_ctl.abort_request, eng_ctl.overload_req,
    eng_ctl.time_triggered_mode, eng_ctl.trigger_sync_select,
    eng_ctl.listen_mode, eng_ctl.test_mode} == wd_r[7:2])
    else $error("mode controls differ from written value");
  a_trig_capture: assert property (
    eng_ctl.trig_capture == cap_r) else $error("timer capture point wrong");
  a_enable_wait: assert property (
    $rose(eng_ctl.enabled_state) |-> rec_r >= 4'hB)
    else $error("enabled before eleven recessive bits");
  a_soft_reset: assert property (
    gcon_wr && reg_wdata[0] |=> eng_ctl.ctrl_reset ##1
    (!eng_ctl.ctrl_reset && !eng_ctl.time_triggered_mode))
    else $error("soft reset pulse or self clear wrong");
  a_status_read: assert property (
    reg_rd && reg_addr == cgcs_pkg::ADDR_GSTA && $stable(eng_lvl) |=>
    (reg_rdata & 8'hFB) == {1'b0, lvl_r.overload_tx, 1'b0, lvl_r.tx_active,
    lvl_r.rx_active, 1'b0, lvl_r.bus_off, lvl_r.error_passive})
    else $error("status read does not match engine levels");
  a_overrun_clear: assert property (
    ovrt_handler_ack && !eng_evt.timer_wrap ##1 !eng_evt.timer_wrap
    |=> !ovrt_irq) else $error("overrun request kept after handler");
  a_abort_busy: assert property (
    abort_r && $past(abort_r) && reg_rd && reg_addr[2] |=> reg_rdata == 8'h00)
    else $error("busy vector not cleared by abort");
  a_global_gate: assert property (
    !gie_r[7] && !gie_p_r[7] |-> !can_irq)
    else $error("controller request while globally disabled");
  a_overrun_gate: assert property (
    !gie_r[0] && !gie_p_r[0] |-> !ovrt_irq)
    else $error("overrun request while its enable is off");
endmodule // cgcs_chk

bind cgcs_top cgcs_chk u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .eng_evt, .eng_lvl, .ovrt_handler_ack,
  .eng_ctl, .can_irq, .ovrt_irq);

// [bench/cgcs_bus_model.sv]
// Far-side bus model: sampled bus bits as other nodes would leave them
`timescale 1ns/1ps
module cgcs_bus_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [4:0] nbits,
  input  wire logic [4:0] dom_at,
  output logic            bit_tick,
  output logic            bus_level
);
  logic [4:0] left_r;
  logic [4:0] idx_r;
  logic [4:0] dom_r;
  logic [1:0] div_r;
  // One bit every four clocks; level is junk between ticks on purpose
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      left_r <= 5'h00;
      idx_r <= 5'h00;
      dom_r <= 5'h1F;
      div_r <= 2'h0;
      bit_tick <= 1'b0;
      bus_level <= 1'b1;
    end else begin
      bit_tick <= 1'b0;
      bus_level <= ~bus_level;
      if (start) begin
        left_r <= nbits;
        idx_r <= 5'h00;
        dom_r <= dom_at;
        div_r <= 2'h0;
      end else if (left_r != 5'h00) begin
        div_r <= div_r + 2'h1;
        if (div_r == 2'h3) begin
          bit_tick <= 1'b1;
          bus_level <= idx_r != dom_r;
          idx_r <= idx_r + 5'h01;
          left_r <= left_r - 5'h01;
        end
      end
    end
  end
endmodule // cgcs_bus_model

// [bench/cgcs_bench.sv]
// Self-checking bench of the CAN general control and status block
`timescale 1ns/1ps
module cgcs_bench;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic [2:0]          reg_addr = 3'h0;
  logic [7:0]          reg_wdata = 8'h00;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [7:0]          reg_rdata;
  logic                ack = 1'b0;
  logic                bufok = 1'b0;
  logic                m_start = 1'b0;
  logic [4:0]          m_n = 5'h00;
  logic [4:0]          m_dom = 5'h1F;
  logic                tick;
  logic                lvl_bit;
  logic                can_irq;
  logic                ovrt_irq;
  cgcs_pkg::cgcs_evt_t evt = '0;
  cgcs_pkg::cgcs_evt_t evt_w;
  cgcs_pkg::cgcs_lvl_t lvl = '0;
  cgcs_pkg::cgcs_ctl_t ctl;
  int                  mismatches = 0;
  int                  checks_done = 0;
  int                  cycles = 0;

  always #5 sys_clk = ~sys_clk;
  // Bus bits come from the far-side model, the rest from the scenarios
  always_comb begin
    evt_w = evt;
    evt_w.bit_tick = tick;
    evt_w.bus_level = lvl_bit;
    evt_w.buf_cfg_rewritten = bufok;
  end
  cgcs_top DUT (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .eng_evt(evt_w), .eng_lvl(lvl), .ovrt_handler_ack(ack),
    .eng_ctl(ctl), .can_irq, .ovrt_irq);
  cgcs_bus_model u_bus (.sys_clk, .rst, .start(m_start), .nbits(m_n),
    .dom_at(m_dom), .bit_tick(tick), .bus_level(lvl_bit));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Gap cycle after each strobe so no strobe is driven twice in a step
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, exp);
    @(posedge sys_clk);
  endtask
  // Event pulses last exactly one cycle, then n-1 idle cycles follow
  task automatic step(input int n);
    @(posedge sys_clk);
    evt <= '0;
    repeat (n - 1) @(posedge sys_clk);
  endtask
  // Capture pulse stands one cycle; look at it mid-cycle
  task automatic cap(input logic [7:0] exp);
    @(negedge sys_clk);
    chk({7'h00, ctl.trig_capture}, exp);
    @(posedge sys_clk);
  endtask
  task automatic bits(input logic [4:0] n, input logic [4:0] d);
    m_start <= 1'b1;
    m_n <= n;
    m_dom <= d;
    step(1);
    m_start <= 1'b0;
    step(4 * int'(n) + 6);
  endtask

  task automatic t_reset;
    for (int a = 0; a < 7; a++) begin
      rd(3'(a), 8'h00);
    end
  endtask
  task automatic t_modes;
    wr(cgcs_pkg::ADDR_GCON, 8'h38);
    rd(cgcs_pkg::ADDR_GCON, 8'h38);
    wr(cgcs_pkg::ADDR_GCON, 8'h20);
    evt.sof <= 1'b1;
    step(1);
    cap(8'h01);
    wr(cgcs_pkg::ADDR_GCON, 8'h30);
    evt.sof <= 1'b1;
    step(1);
    cap(8'h00);
    evt.eof_last <= 1'b1;
    step(1);
    cap(8'h01);
  endtask
  task automatic t_enable;
    wr(cgcs_pkg::ADDR_GCON, 8'h02);
    bits(5'h10, 5'h05);
    rd(cgcs_pkg::ADDR_GSTA, 8'h00);
    bits(5'h01, 5'h1F);
    rd(cgcs_pkg::ADDR_GSTA, 8'h04);
  endtask
  task automatic t_status;
    lvl <= cgcs_pkg::cgcs_lvl_t'(8'hA8);
    step(2);
    rd(cgcs_pkg::ADDR_GSTA, 8'h4D);
    lvl <= cgcs_pkg::cgcs_lvl_t'(8'h40);
    step(2);
    rd(cgcs_pkg::ADDR_GSTA, 8'h14);
  endtask
  task automatic t_irq;
    wr(cgcs_pkg::ADDR_GIE, 8'h83);
    evt.stuff_err <= 1'b1;
    step(2);
    rd(cgcs_pkg::ADDR_GIT, 8'h88);
    chk({7'h00, can_irq}, 8'h01);
    wr(cgcs_pkg::ADDR_GIT, 8'h00);
    rd(cgcs_pkg::ADDR_GIT, 8'h88);
    wr(cgcs_pkg::ADDR_GIT, 8'h08);
    rd(cgcs_pkg::ADDR_GIT, 8'h00);
    lvl <= cgcs_pkg::cgcs_lvl_t'(8'h08);
    step(1);
    lvl <= cgcs_pkg::cgcs_lvl_t'(8'h10);
    step(2);
    rd(cgcs_pkg::ADDR_GIT, 8'h40);
    rd(cgcs_pkg::ADDR_GSTA, 8'h06);
    wr(cgcs_pkg::ADDR_GIE, 8'hC3);
    rd(cgcs_pkg::ADDR_GIT, 8'hC0);
    wr(cgcs_pkg::ADDR_GIT, 8'h40);
    rd(cgcs_pkg::ADDR_GIT, 8'h00);
    evt.timer_wrap <= 1'b1;
    step(2);
    rd(cgcs_pkg::ADDR_GIT, 8'h20);
    chk({6'h00, can_irq, ovrt_irq}, 8'h01);
    ack <= 1'b1;
    step(1);
    ack <= 1'b0;
    step(2);
    rd(cgcs_pkg::ADDR_GIT, 8'h00);
    evt.frame_buf_done <= 1'b1;
    step(2);
    wr(cgcs_pkg::ADDR_GIT, 8'h10);
    rd(cgcs_pkg::ADDR_GIT, 8'h10);
    bufok <= 1'b1;
    wr(cgcs_pkg::ADDR_GIT, 8'h10);
    bufok <= 1'b0;
    rd(cgcs_pkg::ADDR_GIT, 8'h00);
    lvl <= '0;
  endtask
  task automatic t_busy;
    evt.obj_enable <= 15'h4001;
    step(2);
    rd(cgcs_pkg::ADDR_BUSYL, 8'h01);
    rd(cgcs_pkg::ADDR_BUSYH, 8'h40);
    evt.obj_rx_ok <= 15'h0001;
    step(2);
    rd(cgcs_pkg::ADDR_BUSYL, 8'h00);
    evt.obj_enable <= 15'h0006;
    step(2);
    rd(cgcs_pkg::ADDR_BUSYL, 8'h06);
    evt.obj_tx_ok <= 15'h0002;
    evt.obj_disable <= 15'h0004;
    step(2);
    rd(cgcs_pkg::ADDR_BUSYL, 8'h00);
    wr(cgcs_pkg::ADDR_GCON, 8'h82);
    rd(cgcs_pkg::ADDR_BUSYH, 8'h00);
    wr(cgcs_pkg::ADDR_GCON, 8'h80);
    rd(cgcs_pkg::ADDR_GSTA, 8'h00);
    chk({7'h00, ctl.freeze}, 8'h01);
    wr(cgcs_pkg::ADDR_GCON, 8'h00);
  endtask
  task automatic t_softrst;
    wr(cgcs_pkg::ADDR_GCON, 8'h23);
    rd(cgcs_pkg::ADDR_GCON, 8'h00);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      stop_test;
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset;
    t_modes;
    t_enable;
    t_status;
    t_irq;
    t_busy;
    t_softrst;
    stop_test;
  end
endmodule // cgcs_bench
